// >>> design/arc_fault_clear.sv
// fault clear input block: registers, fault word and clear sequencer
module arc_fault_clear (
   input  wire logic               ref_clk,
   input  wire logic               reset_n,
   input  wire logic [7:0]         bus_addr,
   input  wire logic [31:0]        bus_wdata,
   input  wire logic               bus_wr,
   input  wire logic               bus_rd,
   output logic [31:0]             bus_rdata,
   input  wire logic               en_pin,
   input  wire logic [3:0]         io_pins,
   input  wire logic               var_io,
   input  wire logic signed [15:0] ain,
   input  wire logic [15:0]        alarm_set,
   output logic                    drive_en,
   output logic [15:0]             alarm_word,
   output logic                    gp_in,
   output logic signed [17:0]      speed_cmd
);
   // *************************************************************
   // state
   // *************************************************************
   logic [15:0]          gain_reg;
   arc_pkg::arc_cfg_s    cfg_reg;
   logic [7:0]           cmode_reg, en_use_reg;
   logic [3:0]           io_dir_reg;
   logic [15:0]          alarm_reg;
   arc_pkg::arc_state_e  state_reg, state_next;
   logic                 drive_en_reg, gp_in_reg;
   logic [31:0]          rd_data_reg, rd_mux;
   logic                 wr_gain, wr_fci, wr_cmode, wr_enuse;
   logic                 wr_alarm, wr_iodir, fci_ok, force_gp;
   logic [1:0]           new_code;
   logic [2:0]           new_point;
   logic                 sel_raw, lvl, rise, fall;
   logic                 reset_mode, at_normal, clr_edge, hw_clr;
   logic                 new_alarm, supp;
   logic [15:0]          sw_clr, alarm_clr;

   // *************************************************************
   // write decode
   // *************************************************************
   assign wr_gain  = bus_wr && bus_addr == arc_pkg::OFS_GAIN;
   assign wr_fci   = bus_wr && bus_addr == arc_pkg::OFS_FCI;
   assign wr_cmode = bus_wr && bus_addr == arc_pkg::OFS_CMODE;
   assign wr_enuse = bus_wr && bus_addr == arc_pkg::OFS_ENUSE;
   assign wr_alarm = bus_wr && bus_addr == arc_pkg::OFS_ALARM;
   assign wr_iodir = bus_wr && bus_addr == arc_pkg::OFS_IODIR;
   assign new_code  = bus_wdata[arc_pkg::CODE_LSB +: 2];
   assign new_point = bus_wdata[arc_pkg::POINT_LSB +: 3];

   // assignment accepted only in a plain mode, valid code and point
   assign fci_ok = !arc_pkg::is_speed_mode(cmode_reg)
      && new_code != 2'h0
      && (!var_io || ((new_point == 3'h2 || new_point == 3'h4)
      && io_dir_reg[new_point[1:0] - 2'h1]));
   // later speed-change mode or hardware enable-usage writes take the input back
   assign force_gp = (wr_cmode && arc_pkg::is_speed_mode(bus_wdata[7:0]))
      || (wr_enuse && arc_pkg::is_hw_en(bus_wdata[7:0]));

   // *************************************************************
   // configuration registers
   // *************************************************************
   // gain: -32768 would break the symmetric range, so it is dropped
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         gain_reg <= arc_pkg::GAIN_RST;
      end else if (wr_gain && bus_wdata[15:0] != arc_pkg::GAIN_BAD) begin
         gain_reg <= bus_wdata[15:0];
      end
   end

   // input usage and point
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         cfg_reg <= arc_pkg::CFG_RST;
      end else if (force_gp) begin
         cfg_reg.code <= arc_pkg::CODE_GP;
      end else if (wr_fci && fci_ok) begin
         cfg_reg.code <= new_code;
         if (var_io) begin
            cfg_reg.point <= new_point;
         end
      end
   end

   // command mode, enable usage and point directions
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         cmode_reg  <= arc_pkg::CMODE_RST;
         en_use_reg <= arc_pkg::ENUSE_RST;
         io_dir_reg <= arc_pkg::IODIR_RST;
      end else begin
         if (wr_cmode) begin
            cmode_reg <= bus_wdata[7:0];
         end
         if (wr_enuse) begin
            en_use_reg <= bus_wdata[7:0];
         end
         if (wr_iodir) begin
            io_dir_reg <= bus_wdata[3:0];
         end
      end
   end

   // *************************************************************
   // input path
   // *************************************************************
   // a point change switches the debounce input to the new pin; the window count is not restarted
   assign sel_raw = var_io ? io_pins[cfg_reg.point[1:0] - 2'h1] : en_pin;

   arc_debounce u_deb (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .raw_in  (sel_raw),
      .level   (lvl),
      .rise    (rise),
      .fall    (fall)
   );

   // level high means open or de-energized
   assign reset_mode = cfg_reg.code != arc_pkg::CODE_GP;
   assign at_normal  = (cfg_reg.code == arc_pkg::CODE_LOW_CLR)
      ? (lvl == arc_pkg::IN_OPEN) : (lvl != arc_pkg::IN_OPEN);
   assign clr_edge   = (cfg_reg.code == arc_pkg::CODE_LOW_CLR)
      ? fall : rise;
   // only a reserved input may clear; code 3 leaves faults to software
   assign hw_clr     = reset_mode && state_reg == arc_pkg::ST_ARMED
      && clr_edge;
   assign supp       = var_io && arc_pkg::is_hw_en(en_use_reg);

   // *************************************************************
   // fault word
   // *************************************************************
   assign new_alarm = |(alarm_set & arc_pkg::ALARM_MASK);
   assign sw_clr    = wr_alarm ? bus_wdata[15:0] : 16'h0000;
   assign alarm_clr = hw_clr ? 16'hFFFF : sw_clr;

   // a fault arriving with a clear survives it
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         alarm_reg <= arc_pkg::ALARM_RST;
      end else begin
         alarm_reg <= (alarm_reg & ~alarm_clr)
            | (alarm_set & arc_pkg::ALARM_MASK);
      end
   end

   // *************************************************************
   // clear sequencer
   // *************************************************************
   always_comb begin
      state_next = state_reg;
      if (!reset_mode) begin
         state_next = arc_pkg::ST_RUN;
      end else if (new_alarm && (hw_clr || state_reg == arc_pkg::ST_RUN
                   || state_reg == arc_pkg::ST_WAIT_RET)) begin
         // already active at alarm time: must first go back
         state_next = at_normal ? arc_pkg::ST_ARMED
                                : arc_pkg::ST_WAIT_NORM;
      end else begin
         unique case (state_reg)
            arc_pkg::ST_RUN: begin
               if (alarm_reg != 16'h0000) begin
                  state_next = at_normal ? arc_pkg::ST_ARMED
                                         : arc_pkg::ST_WAIT_NORM;
               end
            end
            arc_pkg::ST_WAIT_NORM: begin
               if (at_normal) begin
                  state_next = arc_pkg::ST_ARMED;
               end
            end
            arc_pkg::ST_ARMED: begin
               if (hw_clr || alarm_reg == 16'h0000) begin
                  state_next = arc_pkg::ST_WAIT_RET;
               end
            end
            arc_pkg::ST_WAIT_RET: begin
               if (at_normal) begin
                  state_next = arc_pkg::ST_RUN;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state_reg <= arc_pkg::ST_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   // enable drops on any fault, returns with the input unless hardware enable is set under variable I/O, or on a software clear in code 3
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         drive_en_reg <= 1'b1;
      end else if (new_alarm) begin
         drive_en_reg <= 1'b0;
      end else if (state_reg == arc_pkg::ST_WAIT_RET && reset_mode
                   && at_normal && !supp) begin
         drive_en_reg <= 1'b1;
      end else if (!reset_mode && wr_alarm
                   && (alarm_reg & ~sw_clr) == 16'h0000) begin
         drive_en_reg <= 1'b1;
      end
   end

   // general purpose view of the input, open when reserved
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         gp_in_reg <= arc_pkg::IN_OPEN;
      end else begin
         gp_in_reg <= reset_mode ? arc_pkg::IN_OPEN : lvl;
      end
   end

   arc_gain_scale u_scale (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .gain    (gain_reg),
      .ain     (ain),
      .speed   (speed_cmd)
   );

   // *************************************************************
   // read path
   // *************************************************************
   always_comb begin
      unique case (bus_addr)
         arc_pkg::OFS_GAIN:  rd_mux = {{16{gain_reg[15]}}, gain_reg};
         arc_pkg::OFS_FCI:   rd_mux = {25'h0, cfg_reg.point, 2'h0,
                                       cfg_reg.code};
         arc_pkg::OFS_CMODE: rd_mux = {24'h0, cmode_reg};
         arc_pkg::OFS_ENUSE: rd_mux = {24'h0, en_use_reg};
         arc_pkg::OFS_ALARM: rd_mux = {16'h0, alarm_reg};
         arc_pkg::OFS_ALHEX: rd_mux = {arc_pkg::hex_ascii(alarm_reg[15:12]),
                                       arc_pkg::hex_ascii(alarm_reg[11:8]),
                                       arc_pkg::hex_ascii(alarm_reg[7:4]),
                                       arc_pkg::hex_ascii(alarm_reg[3:0])};
         arc_pkg::OFS_STAT:  rd_mux = {26'h0, state_reg, ~lvl, lvl,
                                       |alarm_reg, drive_en_reg};
         arc_pkg::OFS_IODIR: rd_mux = {28'h0, io_dir_reg};
         arc_pkg::OFS_SPEED: rd_mux = {{14{speed_cmd[17]}}, speed_cmd};
         default:            rd_mux = 32'h0000_0000;
      endcase
   end

   // data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         rd_data_reg <= 32'h0000_0000;
      end else begin
         rd_data_reg <= bus_rd ? rd_mux : 32'h0000_0000;
      end
   end

   assign bus_rdata  = rd_data_reg;
   assign drive_en   = drive_en_reg;
   assign alarm_word = alarm_reg;
   assign gp_in      = gp_in_reg;

   // *************************************************************
   // checks
   // *************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   // a refused write must never reach the gain register
   AST_GAIN_RANGE: assert property (gain_reg != arc_pkg::GAIN_BAD)
      else $error("gain left symmetric range");

   // speed-change modes own the input, so the write is dropped
   AST_FCI_IGNORED: assert property (
      wr_fci && arc_pkg::is_speed_mode(cmode_reg) |=> $stable(cfg_reg))
      else $error("assignment taken in speed-change mode");

   // hardware enable takes the input back from fault clear
   AST_EN_CANCEL: assert property (wr_enuse
      && arc_pkg::is_hw_en(bus_wdata[7:0])
      |=> cfg_reg.code == arc_pkg::CODE_GP)
      else $error("enable usage did not cancel fault clear");

   // a speed-change mode forces the general purpose code
   AST_MODE_FORCE: assert property (wr_cmode
      && arc_pkg::is_speed_mode(bus_wdata[7:0])
      |=> cfg_reg.code == arc_pkg::CODE_GP)
      else $error("speed-change mode did not force code 3");

   // an active edge while armed wipes the whole fault word
   AST_CLEAR_EDGE: assert property (hw_clr && !new_alarm
      |=> alarm_word == 16'h0000 && state_reg == arc_pkg::ST_WAIT_RET)
      else $error("clearing edge did not clear fault word");

   // no clear before the input has been back at its normal level
   AST_NO_EARLY: assert property (state_reg == arc_pkg::ST_WAIT_NORM
      && reset_mode && !wr_alarm |=> alarm_word != 16'h0000)
      else $error("fault cleared without first returning to normal");

   // return to the normal level brings the drive back
   AST_REENABLE: assert property (state_reg == arc_pkg::ST_WAIT_RET
      && reset_mode && at_normal && !supp && !new_alarm
      |=> drive_en && state_reg == arc_pkg::ST_RUN)
      else $error("drive not enabled on return to normal");

   // an external hardware enable keeps the drive off here
   AST_SUPPRESS: assert property (state_reg == arc_pkg::ST_WAIT_RET
      && supp && !drive_en && !wr_alarm |=> !drive_en)
      else $error("drive enabled although hardware enable set");

   // code 0 is refused at the write, so it can never be held
   AST_CODE_VALID: assert property (cfg_reg.code != 2'h0)
      else $error("invalid fault clear code");

   // only the two points that can carry the function are taken
   AST_POINT: assert property (var_io && wr_fci && fci_ok
      |=> cfg_reg.point == 3'h2 || cfg_reg.point == 3'h4)
      else $error("point other than 2 or 4 taken");

   // read data stand for exactly one cycle after the strobe
   AST_READ_WORD: assert property (
      bus_rd && bus_addr == arc_pkg::OFS_ALARM
      |=> bus_rdata == {16'h0, $past(alarm_reg)} ##1 bus_rdata == 32'h0
      || $past(bus_rd))
      else $error("fault word read back wrong");

   // reserved fault bits are never latched
   AST_MASK: assert property (
      (alarm_word & ~arc_pkg::ALARM_MASK) == 16'h0000)
      else $error("reserved fault bit set");

   // code 1 clear by a closing edge
   COV_CLEAR_LOW: cover property (cfg_reg.code == arc_pkg::CODE_LOW_CLR
      && hw_clr);

   // code 2 clear by an opening edge
   COV_CLEAR_HIGH: cover property (cfg_reg.code == arc_pkg::CODE_HIGH_CLR
      && hw_clr);

   // fault raised with the input already active
   COV_WAIT_NORM: cover property (state_reg == arc_pkg::ST_WAIT_NORM
      ##1 state_reg == arc_pkg::ST_ARMED);

   // a later speed-change mode or hardware enable write takes the input back
   COV_FORCE: cover property (force_gp && reset_mode);
endmodule

// >>> design/arc_pkg.sv
// constants, types and helpers of the alarm reset input block
// What this block does
// - gain is signed quarter-rpm, writes of magnitude above 32767 refused
// - gain times full analog input gives gain quarter-rpm speed
// - fault clear assignment ignored while a speed-change mode is active
// - enable-usage write of 1 or 2 after assignment cancels fault clear use
// - speed-change mode or enable usage 1 or 2 forces code 3
// - code 1: open is normal, clear on closing edge only
// - code 1: input closed at alarm needs open then close
// - code 1: drive re-enables once input opens again
// - code 2: mirror of code 1 with levels swapped
// - code 3: input is general purpose; only codes 1, 2, 3 valid
// - host configures the point as input before assigning it
// - variable I/O: only point 2 or 4 accepted
// - variable I/O: re-enable suppressed when hardware enable configured
// - energized input is low/closed, de-energized or open is high
// - fault word readable, also rendered as four hex characters
// - fault word: position 0, ccw 1, cw 2, temp 3, current 7
package arc_pkg;
   // *************************************************************
   // register map
   // *************************************************************
   localparam logic [7:0] OFS_GAIN   = 8'h00;
   localparam logic [7:0] OFS_FCI    = 8'h04;
   localparam logic [7:0] OFS_CMODE  = 8'h08;
   localparam logic [7:0] OFS_ENUSE  = 8'h0C;
   localparam logic [7:0] OFS_ALARM  = 8'h10;
   localparam logic [7:0] OFS_ALHEX  = 8'h14;
   localparam logic [7:0] OFS_STAT   = 8'h18;
   localparam logic [7:0] OFS_IODIR  = 8'h1C;
   localparam logic [7:0] OFS_SPEED  = 8'h20;
   localparam int         CODE_LSB   = 0;
   localparam int         POINT_LSB  = 4;
   // *************************************************************
   // codes and reset values
   // *************************************************************
   localparam logic [1:0]  CODE_LOW_CLR  = 2'h1;
   localparam logic [1:0]  CODE_HIGH_CLR = 2'h2;
   localparam logic [1:0]  CODE_GP       = 2'h3;
   localparam logic [15:0] GAIN_RST      = 16'h0000;
   localparam logic [15:0] GAIN_BAD      = 16'h8000; // -32768 refused
   localparam logic [7:0]  CMODE_RST     = 8'h00;
   localparam logic [7:0]  ENUSE_RST     = 8'h00;
   localparam logic [3:0]  IODIR_RST     = 4'h0;
   localparam logic [15:0] ALARM_RST     = 16'h0000;
   localparam logic        IN_OPEN       = 1'b1;
   localparam int          FW_POS_LIM    = 0;
   localparam int          FW_CCW_LIM    = 1;
   localparam int          FW_CW_LIM     = 2;
   localparam int          FW_OVER_TEMP  = 3;
   localparam int          FW_OVER_CUR   = 7;
   localparam logic [15:0] ALARM_MASK    = 16'h5DFF; // reserved 9,13,15
   // *************************************************************
   // timing and scaling
   // *************************************************************
   localparam int DEB_TIME_NS   = 32'h0001_86A0; // 100 us
   localparam int CLK_PERIOD_NS = 32'h32;        // 20 MHz
   localparam int DEB_CYC = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEB_CW        = 11;
   localparam int AIN_SHIFT     = 14;
   localparam logic signed [15:0] AIN_FULL = 16'sh4000;
   // *************************************************************
   // types
   // *************************************************************
   typedef struct packed {
      logic [2:0] point;
      logic [1:0] code;
   } arc_cfg_s;
   localparam arc_cfg_s CFG_RST = '{point: 3'h2, code: 2'h3};
   typedef enum logic [1:0] {
      ST_RUN       = 2'b00,
      ST_WAIT_NORM = 2'b01,
      ST_ARMED     = 2'b10,
      ST_WAIT_RET  = 2'b11
   } arc_state_e;
   // *************************************************************
   // helpers
   // *************************************************************
   function automatic logic is_speed_mode(input logic [7:0] m);
      return m == 8'h0D || m == 8'h0E || m == 8'h11 || m == 8'h12;
   endfunction
   function automatic logic is_hw_en(input logic [7:0] v);
      return v == 8'h01 || v == 8'h02;
   endfunction
   function automatic logic [7:0] hex_ascii(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
   endfunction
endpackage

// >>> design/arc_debounce.sv
// synchroniser and debouncer for the selected reset input
module arc_debounce (
   input  wire logic ref_clk,
   input  wire logic reset_n,
   input  wire logic raw_in,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic                        s1_reg, s2_reg, lvl_reg, rise_reg, fall_reg;
   logic [arc_pkg::DEB_CW-1:0]  cnt_reg;
   logic                        done;
   localparam logic [arc_pkg::DEB_CW-1:0] CNT_MAX =
      arc_pkg::DEB_CW'(arc_pkg::DEB_CYC - 1);

   // two-flop synchroniser, idle level is open
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         s1_reg <= arc_pkg::IN_OPEN;
         s2_reg <= arc_pkg::IN_OPEN;
      end else begin
         s1_reg <= raw_in;
         s2_reg <= s1_reg;
      end
   end

   assign done = (s2_reg != lvl_reg) && (cnt_reg == CNT_MAX);

   // level changes only after a full stable window
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         cnt_reg  <= '0;
         lvl_reg  <= arc_pkg::IN_OPEN;
         rise_reg <= 1'b0;
         fall_reg <= 1'b0;
      end else begin
         rise_reg <= done && s2_reg;
         fall_reg <= done && !s2_reg;
         if (s2_reg == lvl_reg || done) begin
            cnt_reg <= '0;
         end else begin
            cnt_reg <= cnt_reg + 1'b1;
         end
         if (done) begin
            lvl_reg <= s2_reg;
         end
      end
   end

   assign level = lvl_reg;
   assign rise  = rise_reg;
   assign fall  = fall_reg;

   AST_ONE_EDGE: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (rise || fall) |=> !(rise || fall))
      else $error("debounced edge lasted more than one cycle");
endmodule

// >>> design/arc_gain_scale.sv
// analog input to speed command scaler
module arc_gain_scale (
   input  wire logic               ref_clk,
   input  wire logic               reset_n,
   input  wire logic signed [15:0] gain,
   input  wire logic signed [15:0] ain,
   output logic signed [17:0]      speed
);
   logic signed [31:0] prod;
   logic signed [17:0] speed_reg;

   // full-scale input returns the gain itself, in quarter rpm
   assign prod = gain * ain;
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         speed_reg <= '0;
      end else begin
         speed_reg <= 18'(prod >>> arc_pkg::AIN_SHIFT);
      end
   end
   assign speed = speed_reg;

   AST_FULL_SCALE: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      ain == arc_pkg::AIN_FULL |=> speed == 18'($past(gain)))
      else $error("full-scale input did not give gain speed");
endmodule

// >>> verif/arc_host_model.sv
// host controller model driving the register port of the block
module arc_host_model (
   input  wire logic        ref_clk,
   output logic [7:0]       bus_addr,
   output logic [31:0]      bus_wdata,
   output logic             bus_wr,
   output logic             bus_rd,
   input  wire logic [31:0] bus_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle bus at time zero
   initial begin
      bus_addr = 8'h00;
      bus_wdata = 32'h0000_0000;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
   end
   // one-cycle write; data inverted after so stale data never matches
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge ref_clk);
      bus_wr    <= 1'b0;
      bus_wdata <= ~d;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge ref_clk);
      bus_rd   <= 1'b0;
      @(negedge ref_clk);
      d = bus_rdata;
   endtask
endmodule

// >>> verif/testbench.sv
// self-checking bench of the fault clear input block
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic               ref_clk = 1'b0;
   logic               reset_n = 1'b0;
   logic               en_pin = 1'b1;
   logic [3:0]         io_pins = 4'hF;
   logic               var_io = 1'b0;
   logic signed [15:0] ain = 16'sh4000;
   logic [15:0]        alarm_set = 16'h0000;
   logic [7:0]         bus_addr;
   logic [31:0]        bus_wdata;
   logic               bus_wr;
   logic               bus_rd;
   logic [31:0]        bus_rdata;
   logic               drive_en;
   logic [15:0]        alarm_word;
   logic               gp_in;
   logic signed [17:0] speed_cmd;
   logic [31:0]        rdat;
   logic [7:0]         modes [4] = '{8'h0D, 8'h0E, 8'h11, 8'h12};
   int                 num_errors = 0;
   int                 samples_checked = 0;
   always #25 ref_clk = ~ref_clk;
   arc_host_model i_arc_host_model (.ref_clk(ref_clk), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata));
   arc_fault_clear i_arc_fault_clear (.ref_clk(ref_clk), .reset_n(reset_n),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_rdata(bus_rdata), .en_pin(en_pin),
      .io_pins(io_pins), .var_io(var_io), .ain(ain), .alarm_set(alarm_set),
      .drive_en(drive_en), .alarm_word(alarm_word), .gp_in(gp_in),
      .speed_cmd(speed_cmd));
   // ***************************************************
   // helpers
   // ***************************************************
   task automatic results();
      $display("checked %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      i_arc_host_model.rd(a, rdat);
      chk(rdat, exp);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // pin edges must outlast the 2000-cycle debounce to count
   task automatic pin(input logic v);
      @(posedge ref_clk);
      en_pin <= v;
      io_pins[3] <= v;
   endtask
   // over temperature plus reserved bits, which must not latch
   task automatic fault();
      @(posedge ref_clk);
      alarm_set <= 16'hA208;
      @(posedge ref_clk);
      alarm_set <= 16'h0000;
   endtask
   // bounded wait; a spent bound ends the run
   task automatic wait_st(input logic [15:0] w, input logic e);
      int n;
      n = 0;
      while ((alarm_word !== w || drive_en !== e) && n < 2200) begin
         @(negedge ref_clk);
         n++;
      end
      chk({15'h0, drive_en, alarm_word}, {15'h0, e, w});
      if (n == 2200) begin
         num_errors++;
         results();
      end
   endtask
   // normal level, fault, active edge clears, normal level sets drive enable to en_exp
   task automatic clear_cycle(input logic nl, input logic en_exp);
      pin(nl);
      idle(2100);
      fault();
      wait_st(16'h0008, 1'b0);
      pin(~nl);
      wait_st(16'h0000, 1'b0);
      pin(nl);
      idle(2100);
      wait_st(16'h0000, en_exp);
   endtask
   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      idle(8);
      reset_n <= 1'b1;
      rchk(arc_pkg::OFS_FCI, 32'h0000_0023);
      rchk(arc_pkg::OFS_GAIN, 32'h0000_0000);
      rchk(8'hFC, 32'h0000_0000);
      chk({31'h0, drive_en}, 32'h0000_0001);
      i_arc_host_model.wr(arc_pkg::OFS_GAIN, 32'h0000_0BB8);
      rchk(arc_pkg::OFS_GAIN, 32'h0000_0BB8);
      i_arc_host_model.wr(arc_pkg::OFS_GAIN, 32'h0000_8000);
      rchk(arc_pkg::OFS_GAIN, 32'h0000_0BB8);
      i_arc_host_model.wr(arc_pkg::OFS_GAIN, 32'h0000_8001);
      rchk(arc_pkg::OFS_GAIN, 32'hFFFF_8001);
      idle(3);
      chk({14'h0, speed_cmd}, 32'h0003_8001);
      $display("test gain done");
      i_arc_host_model.wr(arc_pkg::OFS_FCI, 32'h0000_0020);
      rchk(arc_pkg::OFS_FCI, 32'h0000_0023);
      i_arc_host_model.wr(arc_pkg::OFS_FCI, 32'h0000_0021);
      rchk(arc_pkg::OFS_FCI, 32'h0000_0021);
      clear_cycle(1'b1, 1'b1);
      pin(1'b0);
      idle(2100);
      fault();
      wait_st(16'h0008, 1'b0);
      rchk(arc_pkg::OFS_ALHEX, 32'h3030_3038);
      pin(1'b1);
      idle(2100);
      wait_st(16'h0008, 1'b0);
      pin(1'b0);
      wait_st(16'h0000, 1'b0);
      pin(1'b1);
      idle(2100);
      wait_st(16'h0000, 1'b1);
      i_arc_host_model.wr(arc_pkg::OFS_FCI, 32'h0000_0022);
      clear_cycle(1'b0, 1'b1);
      $display("test clear done");
      foreach (modes[i]) begin
         i_arc_host_model.wr(arc_pkg::OFS_CMODE, 32'h0000_0000);
         i_arc_host_model.wr(arc_pkg::OFS_FCI, 32'h0000_0021);
         i_arc_host_model.wr(arc_pkg::OFS_CMODE, {24'h0, modes[i]});
         rchk(arc_pkg::OFS_FCI, 32'h0000_0023);
         i_arc_host_model.wr(arc_pkg::OFS_FCI, 32'h0000_0021);
         rchk(arc_pkg::OFS_FCI, 32'h0000_0023);
      end
      i_arc_host_model.wr(arc_pkg::OFS_CMODE, 32'h0000_0000);
      for (int u = 1; u < 3; u++) begin
         i_arc_host_model.wr(arc_pkg::OFS_FCI, 32'h0000_0021);
         i_arc_host_model.wr(arc_pkg::OFS_ENUSE, 32'(u));
         rchk(arc_pkg::OFS_FCI, 32'h0000_0023);
      end
      pin(1'b0);
      idle(2100);
      chk({31'h0, gp_in}, 32'h0000_0000);
      fault();
      pin(1'b1);
      idle(2100);
      wait_st(16'h0008, 1'b0);
      i_arc_host_model.wr(arc_pkg::OFS_ALARM, 32'h0000_0008);
      wait_st(16'h0000, 1'b1);
      $display("test modes done");
      idle(1);
      reset_n <= 1'b0;
      var_io <= 1'b1;
      idle(8);
      reset_n <= 1'b1;
      i_arc_host_model.wr(arc_pkg::OFS_ENUSE, 32'h0000_0001);
      i_arc_host_model.wr(arc_pkg::OFS_FCI, 32'h0000_0041);
      rchk(arc_pkg::OFS_FCI, 32'h0000_0023);
      i_arc_host_model.wr(arc_pkg::OFS_IODIR, 32'h0000_000C);
      i_arc_host_model.wr(arc_pkg::OFS_FCI, 32'h0000_0031);
      rchk(arc_pkg::OFS_FCI, 32'h0000_0023);
      i_arc_host_model.wr(arc_pkg::OFS_FCI, 32'h0000_0041);
      rchk(arc_pkg::OFS_FCI, 32'h0000_0041);
      clear_cycle(1'b1, 1'b0);
      $display("test variable io done");
      results();
   end
   // watchdog against a hung run
   initial begin
      #(100000 * 50);
      num_errors++;
      results();
   end
endmodule
